//--- logic/user_sense_enable_port.sv
`default_nettype none
module user_sense_enable_port #(
	parameter int unsigned FILTER_CYCLES = sense_enable_pkg::SENSE_FILTER_CYCLES,
	parameter bit          DUAL_PATH     = 1'b1
) (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       cb_cs,
	input  wire logic       cb_read,
	input  wire logic [4:0] cb_addr,
	input  wire logic [7:0] cb_wdata,
	output logic [7:0]      cb_rdata,
	output logic            cb_ack,
	input  wire logic       sense_in_0,
	input  wire logic       sense_in_1,
	input  wire logic       sense_in_2,
	output logic            ctrl_out_pin_0,
	output logic            ctrl_out_pin_1,
	output logic            ctrl_out_pin_2
);

	// ------------------------------------------------------------
	// Sense qualification
	// ------------------------------------------------------------
	wire [2:0] sense_pins;
	wire [2:0] sense_qual;
	wire [2:0] sense_set;

	assign sense_pins = {sense_in_2, sense_in_1, sense_in_0};

	// Pin rise to latch takes the synchroniser stages, the filter window and one more cycle for the latch flop;
	// A pulse shorter than the window is dropped on purpose, not remembered
	// One filter per pin; the glitch filter replaces an unspecified minimum time
	for (genvar i = 0; i < 3; i++) begin : g_filter
		sense_filter #(
			.CYCLES    (FILTER_CYCLES)
		) u_filter (
			.mclk      (mclk),
			.rst       (rst),
			.sense_pin (sense_pins[i]),
			.qualified (sense_qual[i])
		);
	end

	// Path 2 does nothing on a single-path build
	assign sense_set = {sense_qual[2] & DUAL_PATH, sense_qual[1:0]};

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	// Image order: D0 D1 D4 sense, D2 D3 D6 enable, D5 reserved
	logic [2:0] sense_latch_q;
	logic [2:0] out_ctrl;
	logic       reserved;

	wire        reg_hit;
	wire        reg_wr;
	wire        reg_rd;
	wire [2:0]  wr_clear;
	wire [2:0]  next_sense_latch;
	wire [2:0]  next_out_ctrl;
	wire [7:0]  reg_view;

	// Address decode; other addresses belong to other registers
	assign reg_hit = cb_cs && (cb_addr == sense_enable_pkg::USER_SENSE_ENABLE_ADDR);
	assign reg_wr  = reg_hit && !cb_read;
	assign reg_rd  = reg_hit && cb_read;

	// Writing 0 to a sense bit clears it, writing 1 leaves it alone
	assign wr_clear = reg_wr ? ~{cb_wdata[sense_enable_pkg::SENSE_LATCH_2_BIT],
		cb_wdata[sense_enable_pkg::SENSE_LATCH_1_BIT],
		cb_wdata[sense_enable_pkg::SENSE_LATCH_0_BIT]} : 3'h0;

	// Trade-off: a pin still held high sets its bit again at once, so software
	// Keeps seeing the event until its source goes away
	// A new qualified assertion wins over a clear in the same cycle
	assign next_sense_latch = sense_set | (sense_latch_q & ~wr_clear);

	assign next_out_ctrl = reg_wr ? {cb_wdata[sense_enable_pkg::OUT_CTRL_2_BIT] & DUAL_PATH,
		cb_wdata[sense_enable_pkg::OUT_CTRL_1_BIT],
		cb_wdata[sense_enable_pkg::OUT_CTRL_0_BIT]} : out_ctrl;

	// Read image; bit 7 reads zero
	assign reg_view = {1'b0,
		out_ctrl[2],
		reserved,
		sense_latch_q[2],
		out_ctrl[1],
		out_ctrl[0],
		sense_latch_q[1],
		sense_latch_q[0]};

	// Sense latches
	always_ff @(posedge mclk) begin
		if (rst) begin
			sense_latch_q <= 3'h0;
		end else begin
			sense_latch_q <= next_sense_latch;
		end
	end

	// The reserved bit only stores; nothing but the read image looks at it
	// Enable bits and the inert reserved bit
	always_ff @(posedge mclk) begin
		if (rst) begin
			out_ctrl <= 3'h0;
			reserved <= 1'b0;
		end else begin
			out_ctrl <= next_out_ctrl;
			if (reg_wr) begin
				reserved <= cb_wdata[sense_enable_pkg::RESERVED_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// Control bus answer
	// ------------------------------------------------------------
	// Any address is answered, so a stray access never stalls the bus;
	// Only this register's address is decoded for data
	// Every select is answered next cycle; unmapped reads return zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			cb_ack   <= 1'b0;
			cb_rdata <= sense_enable_pkg::USER_SENSE_ENABLE_RST;
		end else begin
			cb_ack   <= cb_cs;
			cb_rdata <= reg_rd ? reg_view : 8'h00;
		end
	end

	// ------------------------------------------------------------
	// Enable pins
	// ------------------------------------------------------------
	// A single-path build masks enable 2 on write, so pin 2 stays low there
	// Straight from the flops, so the pins never glitch
	assign ctrl_out_pin_0 = out_ctrl[0];
	assign ctrl_out_pin_1 = out_ctrl[1];
	assign ctrl_out_pin_2 = out_ctrl[2];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// The !rst term keeps an attempt off a reset edge, where disable iff
	// Already sees the released level and a reset would look like a lost bit
	a_sense_set: assert property (@(posedge mclk) disable iff (rst)
		(!rst && sense_qual[0]) |=> sense_latch_q[0])
		else $error("qualified sense 0 did not latch");

	a_sense_hold: assert property (@(posedge mclk) disable iff (rst)
		(!rst && sense_latch_q[1] && !(reg_wr && !cb_wdata[1])) |=> sense_latch_q[1])
		else $error("sense latch 1 dropped without a clear");

	a_sense_clear: assert property (@(posedge mclk) disable iff (rst)
		(reg_wr && !cb_wdata[0] && !sense_qual[0]) |=> !sense_latch_q[0])
		else $error("sense latch 0 not cleared by write");

	a_pin0_follow: assert property (@(posedge mclk) disable iff (rst)
		reg_wr |=> ctrl_out_pin_0 == $past(cb_wdata[2]))
		else $error("enable pin 0 does not follow written bit");

	a_pin1_follow: assert property (@(posedge mclk) disable iff (rst)
		reg_wr ##1 !reg_wr |=> ctrl_out_pin_1 == $past(cb_wdata[3], 2))
		else $error("enable pin 1 does not hold written bit");

	a_path2_latch: assert property (@(posedge mclk) disable iff (rst)
		sense_qual[2] |=> sense_latch_q[2] == DUAL_PATH)
		else $error("sense latch 2 wrong for build variant");

	a_reserved_reset: assert property (@(posedge mclk)
		rst |=> !reserved && cb_rdata == 8'h00)
		else $error("reserved bit not zero after reset");

	a_pin2_follow: assert property (@(posedge mclk) disable iff (rst)
		reg_wr |=> ctrl_out_pin_2 == ($past(cb_wdata[6]) && DUAL_PATH))
		else $error("enable pin 2 does not follow written bit");

	a_read_image: assert property (@(posedge mclk) disable iff (rst)
		reg_rd |=> cb_ack && cb_rdata[1:0] == $past(sense_latch_q[1:0]))
		else $error("read does not show latched sense bits");

	a_sense1_set: assert property (@(posedge mclk) disable iff (rst)
		(!rst && sense_qual[1]) |=> sense_latch_q[1])
		else $error("qualified sense 1 did not latch");

	a_sense0_hold: assert property (@(posedge mclk) disable iff (rst)
		(!rst && sense_latch_q[0] && !(reg_wr && !cb_wdata[0])) |=> sense_latch_q[0])
		else $error("sense latch 0 dropped without a clear");

	a_path2_hold: assert property (@(posedge mclk) disable iff (rst)
		(!rst && sense_latch_q[2] && !(reg_wr && !cb_wdata[4])) |=> sense_latch_q[2])
		else $error("sense latch 2 dropped without a clear");

	a_sense2_clear: assert property (@(posedge mclk) disable iff (rst)
		(!rst && reg_wr && !cb_wdata[sense_enable_pkg::SENSE_LATCH_2_BIT] && !sense_qual[2]) |=> !sense_latch_q[2])
		else $error("sense latch 2 not cleared by write");

	a_pin0_hold: assert property (@(posedge mclk) disable iff (rst)
		(!rst && !reg_wr) |=> $stable(ctrl_out_pin_0))
		else $error("enable pin 0 moved without a write");

	a_pin2_hold: assert property (@(posedge mclk) disable iff (rst)
		(!rst && !reg_wr) |=> $stable(ctrl_out_pin_2))
		else $error("enable pin 2 moved without a write");

	a_reserved_write: assert property (@(posedge mclk) disable iff (rst)
		(!rst && reg_wr) |=> reserved == $past(cb_wdata[sense_enable_pkg::RESERVED_BIT]))
		else $error("reserved bit does not take written value");

	a_bus_ack: assert property (@(posedge mclk) disable iff (rst)
		!rst |=> cb_ack == $past(cb_cs))
		else $error("control bus answer not one cycle after select");

endmodule : user_sense_enable_port
`default_nettype wire

//--- pkg/sense_enable_pkg.sv
`default_nettype none
package sense_enable_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [4:0] USER_SENSE_ENABLE_ADDR = 5'h17;
	localparam logic [7:0] USER_SENSE_ENABLE_RST  = 8'h00;

	// ------------------------------------------------------------
	// Field positions inside the register
	// ------------------------------------------------------------
	localparam int unsigned SENSE_LATCH_0_BIT = 0;
	localparam int unsigned SENSE_LATCH_1_BIT = 1;
	localparam int unsigned OUT_CTRL_0_BIT    = 2;
	localparam int unsigned OUT_CTRL_1_BIT    = 3;
	localparam int unsigned SENSE_LATCH_2_BIT = 4;
	localparam int unsigned RESERVED_BIT      = 5;
	localparam int unsigned OUT_CTRL_2_BIT    = 6;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	// Qualifying time of a sense pin, in mclk cycles after the synchroniser
	localparam int unsigned SENSE_FILTER_CYCLES = 4;

endpackage : sense_enable_pkg
`default_nettype wire

//--- logic/sense_filter.sv
`default_nettype none
module sense_filter #(
	parameter int unsigned CYCLES = sense_enable_pkg::SENSE_FILTER_CYCLES
) (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic sense_pin,
	output logic      qualified
);

	// ------------------------------------------------------------
	// Synchroniser and run-length filter
	// ------------------------------------------------------------
	localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;

	logic [2:0]    sync;
	logic [CW-1:0] run_cnt;
	wire           agree_high;
	wire           run_done;

	// Only the second and third stages are looked at, never the first
	assign agree_high = sync[1] & sync[2];
	assign run_done   = (run_cnt == CW'(CYCLES - 1));

	// Three-stage capture of the asynchronous pin
	always_ff @(posedge mclk) begin
		if (rst) begin
			sync <= 3'h0;
		end else begin
			sync <= {sync[1:0], sense_pin};
		end
	end

	// A glitch shorter than CYCLES restarts the count and never qualifies
	always_ff @(posedge mclk) begin
		if (rst || !agree_high) begin
			run_cnt   <= '0;
			qualified <= 1'b0;
		end else if (run_done) begin
			qualified <= 1'b1;
		end else begin
			run_cnt   <= run_cnt + CW'(1);
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_filter_drop: assert property (@(posedge mclk) disable iff (rst)
		!agree_high |=> !qualified)
		else $error("sense qualified without a stable high input");

	a_filter_rise: assert property (@(posedge mclk) disable iff (rst)
		$rose(qualified) |-> $past(agree_high) && $past(run_done))
		else $error("sense qualified before the run completed");

endmodule : sense_filter
`default_nettype wire

//--- verif/sense_board_model.sv
`default_nettype none
module sense_board_model (
	input  wire logic       mclk,
	input  wire logic [2:0] hold_req,
	output logic            sense_in_0,
	output logic            sense_in_1,
	output logic            sense_in_2
);
	timeunit 1ns;
	timeprecision 1ns;
	// Board drives push-pull sense lines, low when idle
	initial {sense_in_2, sense_in_1, sense_in_0} = 3'b000;
	always @(posedge mclk) begin
		{sense_in_2, sense_in_1, sense_in_0} <= hold_req;
	end
endmodule : sense_board_model
`default_nettype wire

//--- verif/user_sense_enable_port_tb_top.sv
`default_nettype none
module user_sense_enable_port_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [4:0] RA = sense_enable_pkg::USER_SENSE_ENABLE_ADDR;
	logic       mclk, rst, cb_cs, cb_read, cb_ack, s0, s1, s2, p0, p1, p2;
	logic       sp_ack, sp_p0, sp_p1, sp_p2;
	logic [4:0] cb_addr;
	logic [7:0] cb_wdata, cb_rdata, rd, sp_rdata, rd_sp;
	logic [2:0] hold_req;
	int         n_errors, checks_done;
	user_sense_enable_port DUT (.mclk(mclk), .rst(rst), .cb_cs(cb_cs), .cb_read(cb_read),
		.cb_addr(cb_addr), .cb_wdata(cb_wdata), .cb_rdata(cb_rdata), .cb_ack(cb_ack),
		.sense_in_0(s0), .sense_in_1(s1), .sense_in_2(s2),
		.ctrl_out_pin_0(p0), .ctrl_out_pin_1(p1), .ctrl_out_pin_2(p2));
	// Single-path build beside the dual-path one, on the same bus and pins
	user_sense_enable_port #(.DUAL_PATH(1'b0)) single_path (.mclk(mclk), .rst(rst), .cb_cs(cb_cs),
		.cb_read(cb_read), .cb_addr(cb_addr), .cb_wdata(cb_wdata), .cb_rdata(sp_rdata), .cb_ack(sp_ack),
		.sense_in_0(s0), .sense_in_1(s1), .sense_in_2(s2),
		.ctrl_out_pin_0(sp_p0), .ctrl_out_pin_1(sp_p1), .ctrl_out_pin_2(sp_p2));
	sense_board_model board (.mclk(mclk), .hold_req(hold_req),
		.sense_in_0(s0), .sense_in_1(s1), .sense_in_2(s2));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// ------------------------------------------------------------
	// Compare and bus tasks
	// ------------------------------------------------------------
	task chk_reg(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_reg
	task chk_pins(input logic [2:0] exp);
		checks_done++;
		if ({p2, p1, p0} !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, {p2, p1, p0}, exp);
		end
	endtask : chk_pins
	// One cycle of select; answer lands one cycle later, so sample just past the taking edge
	task access(input logic r, input logic [4:0] a, input logic [7:0] d);
		cb_cs    <= 1'b1;
		cb_read  <= r;
		cb_addr  <= a;
		cb_wdata <= d;
		@(posedge mclk);
		cb_cs <= 1'b0;
		#1;
		rd = cb_ack ? cb_rdata : 8'hxx;
		rd_sp = sp_ack ? sp_rdata : 8'hxx;
		@(posedge mclk);
	endtask : access
	task rd_chk(input logic [4:0] a, input logic [7:0] exp);
		access(1'b1, a, 8'h00);
		chk_reg(rd, exp);
	endtask : rd_chk
	// Hold the chosen sense lines for n cycles, then let the filter settle
	task pulse(input logic [2:0] m, input int n);
		hold_req <= m;
		repeat (n) @(posedge mclk);
		hold_req <= 3'b000;
		repeat (12) @(posedge mclk);
	endtask : pulse
	task end_sim;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : end_sim
	// Watchdog: the whole sequence needs well under 2000 cycles
	initial begin
		#20000;
		n_errors++;
		end_sim();
	end
	initial begin
		n_errors = 0;
		checks_done = 0;
		rst <= 1'b1;
		cb_cs <= 1'b0;
		cb_read <= 1'b0;
		cb_addr <= 5'h00;
		cb_wdata <= 8'h00;
		hold_req <= 3'b000;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd_chk(RA, 8'h00);
		chk_pins(3'b000);
		access(1'b0, RA, 8'h6C);
		chk_pins(3'b111);
		chk_reg({5'h00, sp_p2, sp_p1, sp_p0}, 8'h03);
		rd_chk(RA, 8'h6C);
		chk_reg(rd_sp, 8'h2C);
		access(1'b0, RA, 8'h48);
		chk_pins(3'b110);
		access(1'b0, RA, 8'h04);
		chk_pins(3'b001);
		$display("test pins done");
		pulse(3'b111, 2);
		rd_chk(RA, 8'h04);
		pulse(3'b111, 12);
		rd_chk(RA, 8'h17);
		chk_reg(rd_sp, 8'h07);
		access(1'b0, RA, 8'h17);
		rd_chk(RA, 8'h17);
		access(1'b0, RA, 8'h02);
		rd_chk(RA, 8'h02);
		access(1'b0, RA, 8'h00);
		rd_chk(RA, 8'h00);
		$display("test sense done");
		access(1'b0, 5'h05, 8'hFF);
		rd_chk(5'h05, 8'h00);
		rd_chk(RA, 8'h00);
		chk_pins(3'b000);
		access(1'b0, RA, 8'h20);
		rd_chk(RA, 8'h20);
		rst <= 1'b1;
		@(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd_chk(RA, 8'h00);
		chk_reg(rd_sp, 8'h00);
		$display("test map and reset done");
		end_sim();
	end
endmodule : user_sense_enable_port_tb_top
`default_nettype wire
